// ---- design/dcrc_device.sv ----
/*
  Display controller end: input mode detection, serial shifter, word
  interpreter, display buffer and grid refresh scanner.
  Assumes the link and the sync/master pins are asynchronous to core_clk.
*/
// Decided for this implementation: the register addresses and register access over APB.
// Functional notes
// - Upper data line change selects parallel mode
// - Parallel mode sticks until power-on reset
// - Host strobe: high 1us, low 40us, 60us
// - Serial bits MSB first, data and clock lines
// - Serial strobe latches last eight shifted bits
// - Host: 2us per bit, 60us per byte
// - Serial host keeps upper data lines low
// - Control word only right after prefix 01
// - Prefix then 01 stores 01 as data
// - Codes 05-07 set slot 16/32/64, default 64
// - Codes 08-0A select normal, blank, inverse
// - Halted until start code 0E
// - Only master starts; slaves start on sync
// - Codes 40-7F load six-bit duty register
// - On-time duty minus two, capped 13/29/61
// - Codes 80-9F load digit count, zero 32
// - Codes C0-DF load buffer pointer
// - Low seven bits pattern, top bit cursor
// - Blank or invert marked chars, cursor untouched
// - Pointer advances after each display word
// - Pointer equal to digit count wraps zero
// - Grids one at a time, cursor shares timing
// - Reset values for duty, pointer, digits, slot
`timescale 1ns/1ps
`include "dcrc_map.svh"
module dcrc_device (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Host link
  dcrc_if.dev              link,
  // Cascade pins
  input  wire logic        master_sel,
  input  wire logic        sync_input,
  output      logic        sync_output,
  // Display drive
  output      logic [19:0] grid_outputs,
  output      logic        cursor,
  output      logic [6:0]  char_code,
  output      logic        char_blank,
  output      logic        char_invert,
  output      logic        seg_enable,
  // Status
  output      logic        par_mode,
  output      logic        refresh_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [7:0]  d_s1;
  logic [7:0]  d_s2;
  logic        ld_s1;
  logic        ld_s2;
  logic        ld_q;
  logic        sclk_q;
  logic        sip_s1;
  logic        sip_s2;
  logic        sip_q;
  logic        ms_s1;
  logic        ms_s2;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      d_s1   <= 8'h00;
      d_s2   <= 8'h00;
      ld_s1  <= 1'b0;
      ld_s2  <= 1'b0;
      ld_q   <= 1'b0;
      sclk_q <= 1'b0;
      sip_s1 <= 1'b0;
      sip_s2 <= 1'b0;
      sip_q  <= 1'b0;
      ms_s1  <= 1'b0;
      ms_s2  <= 1'b0;
    end else begin
      d_s1   <= link.data_lines;
      d_s2   <= d_s1;
      ld_s1  <= link.load_strobe;
      ld_s2  <= ld_s1;
      ld_q   <= ld_s2;
      sclk_q <= d_s2[1];
      sip_s1 <= sync_input;
      sip_s2 <= sip_s1;
      sip_q  <= sip_s2;
      ms_s1  <= master_sel;
      ms_s2  <= ms_s1;
    end
  end

  wire ld_rise   = ld_s2 & ~ld_q;
  wire sclk_rise = d_s2[1] & ~sclk_q;
  wire sip_rise  = sip_s2 & ~sip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Input mode: first cycle after reset only primes the compare
  logic        primed;
  logic [5:0]  upper_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      primed   <= 1'b0;
      upper_q  <= 6'h00;
      par_mode <= 1'b0;
    end else begin
      primed  <= 1'b1;
      upper_q <= d_s2[7:2];
      if (primed && (d_s2[7:2] != upper_q)) begin
        par_mode <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter
  logic [7:0]  shift_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
    end else if (!par_mode && sclk_rise) begin
      shift_reg <= {shift_reg[6:0], d_s2[0]};
    end
  end

  // Data and strobe share the synchroniser depth, so no skew between them
  wire [7:0] word = par_mode ? d_s2 : shift_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Word interpreter
  logic        prefix_seen;

  wire is_ctrl = ld_rise & prefix_seen & (word != `DCRC_PREFIX);
  wire is_data = ld_rise & (prefix_seen ? (word == `DCRC_PREFIX)
                                        : (word != `DCRC_PREFIX));

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prefix_seen <= 1'b0;
    end else if (ld_rise) begin
      prefix_seen <= ~prefix_seen & (word == `DCRC_PREFIX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  dcrc_pkg::dcrc_slot_t slot_sel;
  dcrc_pkg::dcrc_mode_t mode;
  logic [5:0]  duty;
  logic [4:0]  digits;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      slot_sel <= dcrc_pkg::DCRC_T64;
      mode     <= dcrc_pkg::DCRC_NORMAL;
      duty     <= `DCRC_RST_DUTY;
      digits   <= `DCRC_RST_DIGITS;
    end else if (is_ctrl) begin
      casez (word)
        `DCRC_DT16:       slot_sel <= dcrc_pkg::DCRC_T16;
        `DCRC_DT32:       slot_sel <= dcrc_pkg::DCRC_T32;
        `DCRC_DT64:       slot_sel <= dcrc_pkg::DCRC_T64;
        `DCRC_MODE_NORM:  mode     <= dcrc_pkg::DCRC_NORMAL;
        `DCRC_MODE_BLANK: mode     <= dcrc_pkg::DCRC_BLANK;
        `DCRC_MODE_INV:   mode     <= dcrc_pkg::DCRC_INVERSE;
        `DCRC_DUTY_PAT:   duty     <= word[5:0];
        `DCRC_DIGITS_PAT: digits   <= word[4:0];
        default: ;
      endcase
    end
  end

  wire [5:0] grid_count = (digits == 5'h00) ? `DCRC_GRID_MAX : {1'b0, digits};

  ////////////////////////////////////////////////////////////////////////////
  // Display buffer and pointer
  logic [7:0]  dbuf [32];
  logic [4:0]  ptr;

  wire [5:0] ptr_inc = {1'b0, ptr} + 6'h01;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ptr <= `DCRC_RST_PTR;
    end else if (is_data) begin
      ptr <= (ptr_inc == grid_count) ? 5'h00 : ptr_inc[4:0];
    end else if (is_ctrl && (word[7:5] == 3'b110)) begin
      ptr <= word[4:0];
    end
  end

  // Reset clears the buffer so the cursor never shows stale bits
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) begin
        dbuf[i] <= 8'h00;
      end
    end else if (is_data) begin
      dbuf[ptr] <= word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh start
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      refresh_running <= 1'b0;
    end else if (ms_s2 && is_ctrl && (word == `DCRC_START)) begin
      refresh_running <= 1'b1;
    end else if (!ms_s2 && sip_rise) begin
      refresh_running <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot timing
  logic [6:0]  slot_len;
  logic [5:0]  slot_cnt;
  logic [4:0]  pos;

  always_comb begin
    case (slot_sel)
      dcrc_pkg::DCRC_T16: slot_len = `DCRC_SLOT16;
      dcrc_pkg::DCRC_T32: slot_len = `DCRC_SLOT32;
      default:            slot_len = `DCRC_SLOT64;
    endcase
  end

  wire [6:0] slot_last = slot_len - 7'h01;
  wire [6:0] on_cap    = slot_len - `DCRC_OFF_CYC;
  wire [5:0] duty_on   = (duty > `DCRC_DUTY_DROP) ? (duty - `DCRC_DUTY_DROP) : 6'h00;
  // Cap keeps three dark cycles between digits to stop ghosting
  wire [5:0] on_time   = ({1'b0, duty_on} > on_cap) ? on_cap[5:0] : duty_on;
  wire [5:0] pos_inc   = {1'b0, pos} + 6'h01;
  wire       window    = refresh_running & (slot_cnt < on_time);

  always_ff @(posedge core_clk) begin
    if (!nrst || !refresh_running) begin
      slot_cnt <= 6'h00;
      pos      <= 5'h00;
    end else if ({1'b0, slot_cnt} == slot_last) begin
      slot_cnt <= 6'h00;
      pos      <= (pos_inc == grid_count) ? 5'h00 : pos_inc[4:0];
    end else begin
      slot_cnt <= slot_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive outputs
  logic [19:0] next_grid;
  wire  [7:0]  cur_char = dbuf[pos];

  for (genvar g = 0; g < 20; g++) begin : g_grid
    assign next_grid[g] = window & (pos == 5'(g));
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      grid_outputs <= 20'h00000;
      cursor       <= 1'b0;
      char_code    <= 7'h00;
      char_blank   <= 1'b0;
      char_invert  <= 1'b0;
      seg_enable   <= 1'b0;
      sync_output  <= 1'b0;
    end else begin
      grid_outputs <= next_grid;
      cursor       <= window & cur_char[7];
      char_code    <= cur_char[6:0];
      char_blank   <= (mode == dcrc_pkg::DCRC_BLANK) & cur_char[7];
      char_invert  <= (mode == dcrc_pkg::DCRC_INVERSE) & cur_char[7];
      seg_enable   <= window;
      // Slaves line up their first slot on this pulse
      sync_output  <= ms_s2 & refresh_running & (slot_cnt == 6'h00) & (pos == 5'h00);
    end
  end

endmodule // dcrc_device

// ---- design/dcrc_map.svh ----
/*
  Constants of the display command and refresh controller: link timing,
  control codes, reset values and the host's register offsets.
  Assumes the includer runs on a 100 MHz core clock.
*/
`ifndef DCRC_MAP_SVH
`define DCRC_MAP_SVH

// Clock rate and time to cycles, rounded up
`define DCRC_CLK_MHZ        100
`define DCRC_CYC(ns)        ((((ns) * `DCRC_CLK_MHZ) + 999) / 1000)

// Link timing in ns
`define DCRC_LD_ON_NS       1000
`define DCRC_LD_OFF_NS      40000
`define DCRC_LD_CYCLE_NS    60000
`define DCRC_SCLK_HALF_NS   1000
`define DCRC_SDATA_HOLD_NS  400
`define DCRC_SCLK_TO_LD_NS  1000

// Control words
`define DCRC_PREFIX         8'h01
`define DCRC_DT16           8'h05
`define DCRC_DT32           8'h06
`define DCRC_DT64           8'h07
`define DCRC_MODE_NORM      8'h08
`define DCRC_MODE_BLANK     8'h09
`define DCRC_MODE_INV       8'h0a
`define DCRC_START          8'h0e
`define DCRC_DUTY_PAT       8'b01??????
`define DCRC_DIGITS_PAT     8'b100?????
`define DCRC_PTR_PAT        8'b110?????

// Slot lengths, off gap and duty offset
`define DCRC_SLOT16         7'h10
`define DCRC_SLOT32         7'h20
`define DCRC_SLOT64         7'h40
`define DCRC_OFF_CYC        7'h03
`define DCRC_DUTY_DROP      6'h02
`define DCRC_GRID_MAX       6'h20

// Reset values
`define DCRC_RST_DUTY       6'h00
`define DCRC_RST_DIGITS     5'h00
`define DCRC_RST_PTR        5'h00

// Host register offsets and bits
`define DCRC_REG_CTRL       8'h00
`define DCRC_REG_TXDATA     8'h04
`define DCRC_REG_STATUS     8'h08
`define DCRC_CTRL_PAR_BIT   0
`define DCRC_STAT_BUSY_BIT  0

`endif

// ---- design/dcrc_pkg.sv ----
/*
  Types shared by both ends of the display controller link.
  Assumes dcrc_map.svh holds the numeric constants.
*/
package dcrc_pkg;

  typedef enum logic [2:0] {
    DCRC_NORMAL  = 3'b001,
    DCRC_BLANK   = 3'b010,
    DCRC_INVERSE = 3'b100
  } dcrc_mode_t;

  typedef enum logic [2:0] {
    DCRC_T16 = 3'b001,
    DCRC_T32 = 3'b010,
    DCRC_T64 = 3'b100
  } dcrc_slot_t;

  typedef enum logic [5:0] {
    DCRC_IDLE   = 6'b000001,
    DCRC_BIT_LO = 6'b000010,
    DCRC_BIT_HI = 6'b000100,
    DCRC_SETTLE = 6'b001000,
    DCRC_STROBE = 6'b010000,
    DCRC_REST   = 6'b100000
  } dcrc_hstate_t;

endpackage

// ---- design/dcrc_if.sv ----
/*
  Link between the host processor end and the display controller end.
  Assumes both ends are in separate clock domains or sample with synchronisers.
*/
`timescale 1ns/1ps
interface dcrc_if;
  logic [7:0] data_lines;
  logic       load_strobe;

  modport host (output data_lines, output load_strobe);
  modport dev  (input  data_lines, input  load_strobe);
endinterface

// ---- design/dcrc_host.sv ----
/*
  Host processor end: APB register slave that sends one byte per write
  over the link, in serial or parallel form, with the link timing.
  Assumes an APB master on core_clk and a controller end on the link.
*/
`timescale 1ns/1ps
`include "dcrc_map.svh"
module dcrc_host #(
  parameter logic [15:0] LD_ON_CYC    = 16'(`DCRC_CYC(`DCRC_LD_ON_NS)),
  parameter logic [15:0] LD_OFF_CYC   = 16'(`DCRC_CYC(`DCRC_LD_OFF_NS)),
  parameter logic [15:0] LD_CYCLE_CYC = 16'(`DCRC_CYC(`DCRC_LD_CYCLE_NS))
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Link
  dcrc_if.host             link
);

  localparam logic [15:0] HALF_CYC = 16'(`DCRC_CYC(`DCRC_SCLK_HALF_NS));
  localparam logic [15:0] HOLD_CYC = 16'(`DCRC_CYC(`DCRC_SDATA_HOLD_NS));
  localparam logic [15:0] TSL_CYC  = 16'(`DCRC_CYC(`DCRC_SCLK_TO_LD_NS));

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  dcrc_pkg::dcrc_hstate_t state;
  logic        ctrl_par;
  logic [7:0]  tx_byte;

  wire busy     = (state != dcrc_pkg::DCRC_IDLE);
  wire acc      = psel & penable & ~pready;
  wire fire     = psel & penable & pready & pwrite;
  wire mapped   = (paddr == `DCRC_REG_CTRL) | (paddr == `DCRC_REG_TXDATA) |
                  (paddr == `DCRC_REG_STATUS);
  // A byte written while busy is dropped; software polls busy first
  wire tx_start = fire & (paddr == `DCRC_REG_TXDATA) & ~busy;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      if (acc) begin
        pslverr <= ~mapped;
        case (paddr)
          `DCRC_REG_CTRL:   prdata <= {31'h00000000, ctrl_par};
          `DCRC_REG_TXDATA: prdata <= {24'h000000, tx_byte};
          `DCRC_REG_STATUS: prdata <= {31'h00000000, busy};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_par <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      if (fire && (paddr == `DCRC_REG_CTRL) && !busy) begin
        ctrl_par <= pwdata[`DCRC_CTRL_PAR_BIT];
      end
      if (tx_start) begin
        tx_byte <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  logic [15:0] tmr;
  logic [15:0] byte_tmr;
  logic [2:0]  bitn;
  logic [7:0]  dline;
  logic        ld;

  assign link.data_lines  = dline;
  assign link.load_strobe = ld;

  always_ff @(posedge core_clk) begin
    if (!nrst || !busy) begin
      byte_tmr <= 16'h0000;
    end else if (byte_tmr != 16'hffff) begin
      byte_tmr <= byte_tmr + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= dcrc_pkg::DCRC_IDLE;
      tmr   <= 16'h0000;
      bitn  <= 3'h7;
      dline <= 8'h00;
      ld    <= 1'b0;
    end else begin
      tmr <= tmr + 16'h0001;
      case (state)
        dcrc_pkg::DCRC_IDLE: begin
          tmr  <= 16'h0000;
          bitn <= 3'h7;
          if (tx_start) begin
            if (ctrl_par) begin
              dline <= pwdata[7:0];
              state <= dcrc_pkg::DCRC_SETTLE;
            end else begin
              dline <= {7'h00, pwdata[7]};
              state <= dcrc_pkg::DCRC_BIT_LO;
            end
          end
        end
        dcrc_pkg::DCRC_BIT_LO: begin
          if (tmr == HOLD_CYC) begin
            dline <= {7'h00, tx_byte[bitn]};
          end
          if (tmr == HALF_CYC - 16'h0001) begin
            tmr   <= 16'h0000;
            dline <= {6'h00, 1'b1, dline[0]};
            state <= dcrc_pkg::DCRC_BIT_HI;
          end
        end
        dcrc_pkg::DCRC_BIT_HI: begin
          if (tmr == HALF_CYC - 16'h0001) begin
            tmr   <= 16'h0000;
            dline <= {7'h00, dline[0]};
            bitn  <= bitn - 3'h1;
            state <= (bitn == 3'h0) ? dcrc_pkg::DCRC_SETTLE : dcrc_pkg::DCRC_BIT_LO;
          end
        end
        dcrc_pkg::DCRC_SETTLE: begin
          if (tmr == TSL_CYC - 16'h0001) begin
            tmr   <= 16'h0000;
            ld    <= 1'b1;
            state <= dcrc_pkg::DCRC_STROBE;
          end
        end
        dcrc_pkg::DCRC_STROBE: begin
          if (tmr == LD_ON_CYC - 16'h0001) begin
            tmr   <= 16'h0000;
            ld    <= 1'b0;
            state <= dcrc_pkg::DCRC_REST;
          end
        end
        dcrc_pkg::DCRC_REST: begin
          if ((tmr >= LD_OFF_CYC - 16'h0001) && (byte_tmr >= LD_CYCLE_CYC - 16'h0001)) begin
            state <= dcrc_pkg::DCRC_IDLE;
          end
        end
        default: state <= dcrc_pkg::DCRC_IDLE;
      endcase
    end
  end

endmodule // dcrc_host

// ---- dv/dcrc_assertions.sv ----
/*
  Wire checks on the host to controller link: strobe timing, serial framing
  and the parallel mode latch.
  Assumes one core_clk domain and the link signals handed in as plain inputs.
*/
`timescale 1ns/1ps
module dcrc_assertions #(
  parameter logic [15:0] LD_ON_CYC    = 16'h0064,
  parameter logic [15:0] LD_CYCLE_CYC = 16'h1770
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Link and mode
  input  wire logic [7:0] data_lines,
  input  wire logic       load_strobe,
  input  wire logic       par_mode
);
  localparam int SCLK_MIN = 100;
  localparam int SCLK_MAX = 2000;
  logic [15:0] hi_cnt;
  logic [15:0] cyc_cnt;
  logic [15:0] sc_hi;
  ////////////////////////////////////////////////////////////////
  // cyc_cnt and sc_hi saturate so a long idle never wraps into a false fail, nor a stuck-high clock into a false pass
  always_ff @(posedge core_clk)
    hi_cnt <= (!nrst || !load_strobe) ? 16'h0000 : hi_cnt + 16'h0001;
  always_ff @(posedge core_clk)
    cyc_cnt <= !nrst ? 16'hffff : (load_strobe && hi_cnt == 16'h0000) ? 16'h0001
             : cyc_cnt + {15'h0000, cyc_cnt != 16'hffff};
  always_ff @(posedge core_clk)
    sc_hi <= (!nrst || !data_lines[1]) ? 16'h0000 : sc_hi + {15'h0000, sc_hi != 16'hffff};
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_strobe_on_len: assert property (
    $fell(load_strobe) |-> hi_cnt == LD_ON_CYC) else $error("strobe high time wrong");
  a_load_cycle: assert property (
    $rose(load_strobe) |-> cyc_cnt >= LD_CYCLE_CYC) else $error("load cycle too short");
  a_par_cause: assert property (
    $rose(par_mode) |-> $past(data_lines[7:2], 8) == 6'h00 && data_lines[7:2] != 6'h00)
    else $error("parallel mode without upper line change");
  a_par_sticky: assert property (
    $past(par_mode) |-> par_mode) else $error("parallel mode dropped");
  a_ser_steady: assert property (
    !par_mode && data_lines[1] && $past(data_lines[1]) |-> $stable(data_lines[0]))
    else $error("serial data moved while clock high");
  a_ser_hold: assert property (
    !par_mode && $fell(data_lines[1]) |-> $stable(data_lines[0]) [*8])
    else $error("serial data hold too short");
  a_sclk_high: assert property (
    !par_mode && $fell(data_lines[1]) |-> sc_hi >= SCLK_MIN && sc_hi <= SCLK_MAX)
    else $error("serial clock high time wrong");
  a_strobe_sclk_lo: assert property (
    load_strobe && !par_mode |-> !data_lines[1] && data_lines[7:2] == 6'h00)
    else $error("serial strobe with clock or upper lines high");
endmodule // dcrc_assertions

// ---- dv/tb_top.sv ----
/*
  Self-checking bench: APB orders into the host end, link to the controller
  end, display outputs judged at the ports.
  Assumes a 100 MHz core_clk and shortened host strobe counts.
*/
`timescale 1ns/1ps
`include "dcrc_map.svh"
module tb_top;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        master_sel, sync_input, sync_output, cursor, char_blank;
  logic        char_invert, seg_enable, par_mode, refresh_running;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] grid_outputs;
  logic [6:0]  char_code;
  int          failures, total_checks, per, on;
  dcrc_if link();
  // Short strobe counts keep parallel bytes cheap; the device needs only a few cycles
  dcrc_host #(.LD_ON_CYC(16'h0004), .LD_OFF_CYC(16'h0014), .LD_CYCLE_CYC(16'h0028)) dcrc_host_i (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  dcrc_device dcrc_device_i (.core_clk(core_clk), .nrst(nrst), .link(link),
    .master_sel(master_sel), .sync_input(sync_input), .sync_output(sync_output),
    .grid_outputs(grid_outputs), .cursor(cursor), .char_code(char_code),
    .char_blank(char_blank), .char_invert(char_invert), .seg_enable(seg_enable),
    .par_mode(par_mode), .refresh_running(refresh_running));
  dcrc_assertions #(.LD_ON_CYC(16'h0004), .LD_CYCLE_CYC(16'h0028)) dcrc_assertions_i (
    .core_clk(core_clk), .nrst(nrst), .data_lines(link.data_lines),
    .load_strobe(link.load_strobe), .par_mode(par_mode));
  ////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No cycle budget here: only the watchdog ends a stuck access
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy polling; a write while busy would be dropped silently
  task automatic idle();
    int n;
    rd = 32'h1;
    for (n = 0; n < 4000 && rd[`DCRC_STAT_BUSY_BIT] !== 1'b0; n++)
      apb(1'b0, `DCRC_REG_STATUS, 32'h0);
    check("idle", 32'(rd[`DCRC_STAT_BUSY_BIT]), 32'h0);
  endtask
  task automatic send(input logic [7:0] b);
    idle();
    apb(1'b1, `DCRC_REG_TXDATA, {24'h0, b});
  endtask
  task automatic ctl(input logic [7:0] b);
    send(`DCRC_PREFIX);
    send(b);
  endtask
  task automatic settle();
    idle();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wait_grid(input logic [19:0] g);
    int n;
    for (n = 0; n < 20000 && grid_outputs !== g; n++) @(posedge core_clk);
    check("grid", 32'(grid_outputs), 32'(g));
  endtask
  // Slot length from grid 1 start to grid 0 start, then grid 0 on-time
  task automatic meas();
    repeat (2) begin
      wait_grid(20'h00001);
      wait_grid(20'h00002);
      for (per = 0; per < 200 && grid_outputs[0] !== 1'b1; per++) @(posedge core_clk);
      for (on = 0; on < 200 && grid_outputs[0] === 1'b1; on++) @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge core_clk);
    check("grid", 32'(grid_outputs), 32'h0);
    check("running", 32'(refresh_running), 32'h0);
    check("parallel", 32'(par_mode), 32'h0);
    check("sync", 32'(sync_output), 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b0, `DCRC_REG_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_serial();
    send(8'h01);
    send(8'h01);
    send(8'h85);
    ctl(8'h82);
    ctl(8'h4f);
    settle();
    check("halted", 32'(refresh_running), 32'h0);
    ctl(`DCRC_START);
    settle();
    check("running", 32'(refresh_running), 32'h1);
    wait_grid(20'h00001);
    check("char0", 32'(char_code), 32'h01);
    check("cursor0", 32'(cursor), 32'h0);
    wait_grid(20'h00002);
    check("char1", 32'(char_code), 32'h05);
    check("cursor1", 32'(cursor), 32'h1);
    check("seg", 32'(seg_enable), 32'h1);
    meas();
    check("slot", per, 64);
    check("on", on, 13);
    $display("t_serial done");
  endtask
  task automatic t_parallel();
    apb(1'b1, `DCRC_REG_CTRL, 32'h1);
    send(8'h41);
    settle();
    check("parallel", 32'(par_mode), 32'h1);
    ctl(8'hc0);
    send(8'hc2);
    send(8'h03);
    send(8'h44);
    settle();
    wait_grid(20'h00001);
    check("wrapped", 32'(char_code), 32'h44);
    wait_grid(20'h00002);
    check("char1", 32'(char_code), 32'h03);
    $display("t_parallel done");
  endtask
  task automatic t_modes();
    ctl(8'hc0);
    send(8'hc4);
    for (int i = 0; i < 3; i++) begin
      ctl(8'h08 + 8'(i));
      settle();
      wait_grid(20'h00001);
      check("cursor", 32'(cursor), 32'h1);
      check("blank", 32'(char_blank), 32'(i == 1));
      check("invert", 32'(char_invert), 32'(i == 2));
      wait_grid(20'h00002);
      check("plain", 32'({char_blank, char_invert}), 32'h0);
    end
    $display("t_modes done");
  endtask
  task automatic t_timing();
    int sc[5] = '{5, 6, 7, 7, 6};
    int dc[5] = '{'h7f, 'h7f, 'h7f, 'h45, 'h50};
    int ps[5] = '{16, 32, 64, 64, 32};
    int os[5] = '{13, 29, 61, 3, 14};
    int un[6] = '{'h00, 'h0b, 'h3f, 'ha5, 'he3, 'h04};
    for (int i = 0; i < 5; i++) begin
      ctl(8'(sc[i]));
      ctl(8'(dc[i]));
      settle();
      meas();
      check("slot", per, ps[i]);
      check("on", on, os[i]);
    end
    foreach (un[i]) ctl(8'(un[i]));
    settle();
    meas();
    check("slot kept", per, 32);
    check("on kept", on, 14);
    wait_grid(20'h00001);
    check("char kept", 32'(char_code), 32'h44);
    check("mode kept", 32'(char_invert), 32'h1);
    ctl(8'h80);
    settle();
    wait_grid(20'h00004);
    $display("t_timing done");
  endtask
  task automatic t_slave();
    int n;
    for (n = 0; n < 5000 && sync_output !== 1'b1; n++) @(posedge core_clk);
    check("sync pulse", 32'(sync_output), 32'h1);
    nrst <= 1'b0;
    master_sel <= 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("serial again", 32'(par_mode), 32'h0);
    check("grid off", 32'(grid_outputs), 32'h0);
    ctl(`DCRC_START);
    settle();
    check("slave halted", 32'(refresh_running), 32'h0);
    sync_input <= 1'b1;
    for (n = 0; n < 50 && refresh_running !== 1'b1; n++) @(posedge core_clk);
    check("slave run", 32'(refresh_running), 32'h1);
    $display("t_slave done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, sync_input} = 4'h0;
    master_sel = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_serial();
    t_parallel();
    t_modes();
    t_timing();
    t_slave();
    complete_run();
  end
  // About three times the expected run; a hang lands in the same verdict
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
endmodule // tb_top
